// File: etoc_exposure_timer.sv
// Operation
// - exposure length equals multiplier times the selected tick period
// - tick period resets to 20 us standard, 31 us alternate
// - multiplier holds integers 1 through 4095 in twelve bits
// - tick period steps are 1 us standard, 31 us alternate
// - standard tick period reaches 10000000 us
// - absolute exposure is settable in whole microseconds
// - absolute write recomputes the multiplier from the current tick period
// - absolute value is rounded to the nearest achievable exposure
// - multiplier or tick change refreshes the readable absolute exposure
// - standard variant may expose while the previous image reads out
// - overlap has no enable; it follows from trigger spacing alone
// - triggers violating either overlap condition are ignored
// - non-overlapped mode finishes exposure and readout before next start
// - trigger-safe flag high when safe, low on start, high again later
//
// Added by the designer: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "etoc_consts.svh"

module etoc_exposure_timer #(
    parameter bit ALT_VARIANT = 1'b0,
    parameter int TICK_W      = 24,
    parameter int ABS_W       = 36
) (
    // clock and reset
    input  wire logic                clk_in,
    input  wire logic                rst_in,
    // register port
    input  wire etoc_pkg::etoc_bus_s bus_in,
    output logic [31:0]              rdata_out,
    // trigger pin
    input  wire logic                external_trigger_in,
    // acquisition status
    output logic                     trigger_safe_flag_out,
    output logic                     exposure_active_out,
    output logic                     readout_active_out
);
    import etoc_pkg::*;

    localparam logic [TICK_W-1:0] STEP_US   = ALT_VARIANT ? `ETOC_TICK_ALT_STEP_US
                                                          : `ETOC_TICK_STD_STEP_US;
    localparam logic [TICK_W-1:0] RST_US    = ALT_VARIANT ? `ETOC_TICK_ALT_RST_US
                                                          : `ETOC_TICK_STD_RST_US;
    localparam logic [TICK_W-1:0] RST_STEPS = RST_US / STEP_US;
    localparam logic [TICK_W-1:0] MAX_STEPS = `ETOC_TICK_MAX_US / STEP_US;
    localparam logic [5:0]        US_LAST   = 6'(`ETOC_CYC_PER_US - 1);

    // settings
    logic [11:0]       mult;
    logic [TICK_W-1:0] tick_steps;
    logic [TICK_W-1:0] period_us;
    logic [ABS_W-1:0]  exp_abs;
    logic [TICK_W-1:0] readout_us;
    logic              acq_en;

    // trigger synchroniser
    logic trig_s1;
    logic trig_s2;
    logic trig_s3;
    logic trig_edge;

    // exposure timing
    logic              exposing;
    logic [5:0]        exp_pre;
    logic [TICK_W-1:0] exp_us;
    logic [TICK_W-1:0] exp_period;
    logic [11:0]       exp_left;
    logic              exp_us_tick;
    logic              exp_end;

    // readout timing
    logic              reading;
    logic [5:0]        rd_pre;
    logic [TICK_W-1:0] rd_left;

    // acceptance
    logic              safe;
    logic              accept;
    logic              overlapped;
    logic [15:0]       ignored;

    // divider for absolute writes
    etoc_div_e         div_state;
    logic [ABS_W:0]    div_num;
    logic [TICK_W:0]   div_rem;
    logic [5:0]        div_cnt;
    logic [TICK_W:0]   div_shift;
    logic              abs_wr;

    logic wr_mult;
    logic wr_tick;

    assign wr_mult = bus_in.wr && bus_in.addr == `ETOC_OFS_MULT && div_state == DIV_IDLE;
    assign wr_tick = bus_in.wr && bus_in.addr == `ETOC_OFS_TICK && div_state == DIV_IDLE;
    assign abs_wr  = bus_in.wr && bus_in.addr == `ETOC_OFS_ABS_LO && div_state == DIV_IDLE;

    // multiplier register, also loaded by the absolute-write divider
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            mult <= `ETOC_MULT_RST;
        end else if (div_state == DIV_DONE) begin
            if (div_num[ABS_W:0] == '0) begin
                mult <= `ETOC_MULT_MIN;
            end else if (div_num[ABS_W:12] != '0) begin
                mult <= `ETOC_MULT_MAX;
            end else begin
                mult <= div_num[11:0];
            end
        end else if (wr_mult) begin
            if (bus_in.wdata[11:0] == 12'h000 || bus_in.wdata[31:12] != '0) begin
                mult <= bus_in.wdata[31:12] != '0 ? `ETOC_MULT_MAX : `ETOC_MULT_MIN;
            end else begin
                mult <= bus_in.wdata[11:0];
            end
        end
    end

    // tick period held in steps; the period in microseconds follows from it
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            tick_steps <= RST_STEPS;
        end else if (wr_tick) begin
            if (bus_in.wdata[TICK_W-1:0] == '0) begin
                tick_steps <= 24'h000001;
            end else if (bus_in.wdata[31:TICK_W] != '0 || bus_in.wdata[TICK_W-1:0] > MAX_STEPS) begin
                tick_steps <= MAX_STEPS;
            end else begin
                tick_steps <= bus_in.wdata[TICK_W-1:0];
            end
        end
    end

    // registered products keep the multiplier paths short
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            period_us <= RST_US;
            exp_abs   <= ABS_W'(RST_US);
        end else begin
            period_us <= TICK_W'(tick_steps * STEP_US);
            exp_abs   <= ABS_W'(mult) * ABS_W'(period_us);
        end
    end

    // other software settings
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            readout_us <= `ETOC_READOUT_RST_US;
            acq_en     <= 1'b0;
        end else if (bus_in.wr) begin
            if (bus_in.addr == `ETOC_OFS_READOUT) begin
                readout_us <= bus_in.wdata[TICK_W-1:0] == '0 ? 24'h000001
                                                             : bus_in.wdata[TICK_W-1:0];
            end
            if (bus_in.addr == `ETOC_OFS_CTRL) begin
                acq_en <= bus_in.wdata[`ETOC_CTRL_ACQ_EN];
            end
        end
    end

    // rounding divider: (abs + period/2) / period, one quotient bit a cycle
    assign div_shift = {div_rem[TICK_W-1:0], div_num[ABS_W]};

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            div_state <= DIV_IDLE;
            div_num   <= '0;
            div_rem   <= '0;
            div_cnt   <= '0;
        end else begin
            case (div_state)
                DIV_IDLE: begin
                    if (abs_wr) begin
                        // period_us lags a tick write by one cycle; use the live period
                        div_num   <= (ABS_W+1)'(bus_in.wdata)
                                   + (ABS_W+1)'(TICK_W'(tick_steps * STEP_US) >> 1);
                        div_rem   <= '0;
                        div_cnt   <= `ETOC_DIV_STEPS;
                        div_state <= DIV_RUN;
                    end
                end
                DIV_RUN: begin
                    if (div_shift >= {1'b0, period_us}) begin
                        div_rem <= div_shift - {1'b0, period_us};
                        div_num <= {div_num[ABS_W-1:0], 1'b1};
                    end else begin
                        div_rem <= div_shift;
                        div_num <= {div_num[ABS_W-1:0], 1'b0};
                    end
                    div_cnt <= div_cnt - 6'h01;
                    if (div_cnt == 6'h01) begin
                        div_state <= DIV_DONE;
                    end
                end
                DIV_DONE: begin
                    div_state <= DIV_IDLE;
                end
                default: begin
                    div_state <= DIV_IDLE;
                end
            endcase
        end
    end

    // trigger pin synchroniser and rising-edge detect
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            trig_s1 <= 1'b0;
            trig_s2 <= 1'b0;
            trig_s3 <= 1'b0;
        end else begin
            trig_s1 <= external_trigger_in;
            trig_s2 <= trig_s1;
            trig_s3 <= trig_s2;
        end
    end

    assign trig_edge = trig_s2 && !trig_s3;

    // overlap is never switched on; it follows from whether readout still runs
    always_comb begin
        if (exposing || div_state != DIV_IDLE) begin
            safe = 1'b0;
        end else if (!reading) begin
            safe = 1'b1;
        end else if (ALT_VARIANT) begin
            safe = 1'b0;
        end else begin
            // exposure may not finish before the old readout does
            safe = exp_abs >= ABS_W'(rd_left);
        end
    end

    assign accept = trig_edge && acq_en && safe;

    // exposure: microsecond prescaler, tick prescaler, multiplier down-counter
    assign exp_us_tick = exposing && exp_pre == US_LAST;
    assign exp_end     = exp_us_tick && exp_us == exp_period - 24'h000001
                         && exp_left == 12'h001;

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            exposing   <= 1'b0;
            exp_pre    <= '0;
            exp_us     <= '0;
            exp_period <= RST_US;
            exp_left   <= '0;
        end else if (accept) begin
            // settings are latched so a write mid-exposure cannot stretch it
            exposing   <= 1'b1;
            exp_pre    <= '0;
            exp_us     <= '0;
            exp_period <= TICK_W'(tick_steps * STEP_US);
            exp_left   <= mult;
        end else if (exposing) begin
            exp_pre <= exp_us_tick ? 6'h00 : exp_pre + 6'h01;
            if (exp_us_tick) begin
                if (exp_us == exp_period - 24'h000001) begin
                    exp_us   <= '0;
                    exp_left <= exp_left - 12'h001;
                    if (exp_left == 12'h001) begin
                        exposing <= 1'b0;
                    end
                end else begin
                    exp_us <= exp_us + 24'h000001;
                end
            end
        end
    end

    // readout starts as exposure ends and runs for the programmed time
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            reading <= 1'b0;
            rd_pre  <= '0;
            rd_left <= '0;
        end else if (exp_end) begin
            reading <= 1'b1;
            rd_pre  <= '0;
            rd_left <= readout_us;
        end else if (reading) begin
            rd_pre <= rd_pre == US_LAST ? 6'h00 : rd_pre + 6'h01;
            if (rd_pre == US_LAST) begin
                rd_left <= rd_left - 24'h000001;
                if (rd_left == 24'h000001) begin
                    reading <= 1'b0;
                end
            end
        end
    end

    // trigger bookkeeping
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            overlapped <= 1'b0;
            ignored    <= '0;
        end else begin
            if (accept) begin
                overlapped <= reading;
            end
            if (trig_edge && acq_en && !safe && ignored != 16'hffff) begin
                ignored <= ignored + 16'h0001;
            end
        end
    end

    // status outputs
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            trigger_safe_flag_out <= 1'b0;
            exposure_active_out   <= 1'b0;
            readout_active_out    <= 1'b0;
        end else begin
            trigger_safe_flag_out <= acq_en && safe && !accept;
            exposure_active_out   <= accept || (exposing && !exp_end);
            readout_active_out    <= exp_end || (reading
                                     && !(rd_pre == US_LAST && rd_left == 24'h000001));
        end
    end

    // read data, one cycle after the strobe
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rdata_out <= '0;
        end else if (bus_in.rd) begin
            case (bus_in.addr)
                `ETOC_OFS_MULT:    rdata_out <= {20'h00000, mult};
                `ETOC_OFS_TICK:    rdata_out <= {8'h00, tick_steps};
                `ETOC_OFS_ABS_LO:  rdata_out <= exp_abs[31:0];
                `ETOC_OFS_ABS_HI:  rdata_out <= {28'h0000000, exp_abs[ABS_W-1:32]};
                `ETOC_OFS_READOUT: rdata_out <= {8'h00, readout_us};
                `ETOC_OFS_CTRL:    rdata_out <= {31'h00000000, acq_en};
                `ETOC_OFS_STATUS: begin
                    rdata_out <= '0;
                    rdata_out[`ETOC_ST_EXPOSING]   <= exposing;
                    rdata_out[`ETOC_ST_READING]    <= reading;
                    rdata_out[`ETOC_ST_TRIG_SAFE]  <= trigger_safe_flag_out;
                    rdata_out[`ETOC_ST_DIV_BUSY]   <= div_state != DIV_IDLE;
                    rdata_out[`ETOC_ST_OVERLAPPED] <= overlapped;
                end
                `ETOC_OFS_IGNORED: rdata_out <= {16'h0000, ignored};
                default:           rdata_out <= '0;
            endcase
        end else begin
            rdata_out <= '0;
        end
    end

endmodule : etoc_exposure_timer

`default_nettype wire

// File: etoc_consts.svh
`ifndef ETOC_CONSTS_SVH
`define ETOC_CONSTS_SVH

// register offsets (byte addresses)
`define ETOC_OFS_MULT       8'h00
`define ETOC_OFS_TICK       8'h04
`define ETOC_OFS_ABS_LO     8'h08
`define ETOC_OFS_ABS_HI     8'h0c
`define ETOC_OFS_READOUT    8'h10
`define ETOC_OFS_CTRL       8'h14
`define ETOC_OFS_STATUS     8'h18
`define ETOC_OFS_IGNORED    8'h1c

// exposure multiplier field
`define ETOC_MULT_MIN       12'h001
`define ETOC_MULT_MAX       12'hfff
`define ETOC_MULT_RST       12'h001

// tick period, in microseconds
`define ETOC_TICK_STD_RST_US  24'h000014
`define ETOC_TICK_ALT_RST_US  24'h00001f
`define ETOC_TICK_STD_STEP_US 24'h000001
`define ETOC_TICK_ALT_STEP_US 24'h00001f
`define ETOC_TICK_MAX_US      24'h989680

// readout time reset, in microseconds
`define ETOC_READOUT_RST_US 24'h0003e8

// clock timing
`define ETOC_CLK_PERIOD_NS  20
`define ETOC_US_NS          1000
`define ETOC_CYC_PER_US     (`ETOC_US_NS / `ETOC_CLK_PERIOD_NS)

// control and status bit positions
`define ETOC_CTRL_ACQ_EN    0
`define ETOC_ST_EXPOSING    0
`define ETOC_ST_READING     1
`define ETOC_ST_TRIG_SAFE   2
`define ETOC_ST_DIV_BUSY    3
`define ETOC_ST_OVERLAPPED  4

// divider length: quotient bits produced
`define ETOC_DIV_STEPS      6'h25

`endif

// File: etoc_pkg.sv
`default_nettype none

package etoc_pkg;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } etoc_bus_s;

    typedef enum logic [1:0] {
        DIV_IDLE = 2'b00,
        DIV_RUN  = 2'b01,
        DIV_DONE = 2'b10
    } etoc_div_e;

endpackage : etoc_pkg

`default_nettype wire

// File: etoc_props.sv
`timescale 1ns/1ps
`default_nettype none

module etoc_props (
    // clock and reset
    input wire logic                clk_in,
    input wire logic                rst_in,
    // register port
    input wire etoc_pkg::etoc_bus_s bus_in,
    input wire logic [31:0]         rdata_out,
    // trigger and status
    input wire logic                external_trigger_in,
    input wire logic                trigger_safe_flag_out,
    input wire logic                exposure_active_out,
    input wire logic                readout_active_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);

    property p_rd_idle;
        !$past(bus_in.rd) |-> rdata_out == 32'h0;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not zero outside read slot");

    property p_safe_drop;
        $rose(exposure_active_out) |-> !trigger_safe_flag_out;
    endproperty
    a_safe_drop: assert property (p_safe_drop) else $error("safe flag high at start");

    property p_safe_exp;
        exposure_active_out |-> !trigger_safe_flag_out;
    endproperty
    a_safe_exp: assert property (p_safe_exp) else $error("safe flag high in exposure");

    property p_safe_rise;
        $rose(trigger_safe_flag_out) |-> !exposure_active_out;
    endproperty
    a_safe_rise: assert property (p_safe_rise) else $error("safe flag rose in exposure");

    property p_exp_cause;
        $rose(exposure_active_out) |-> $past(external_trigger_in, 3)
            || $past(external_trigger_in, 4) || $past(external_trigger_in, 5);
    endproperty
    a_exp_cause: assert property (p_exp_cause) else $error("exposure without trigger");

    property p_exp_min;
        $rose(exposure_active_out) |-> exposure_active_out [*8];
    endproperty
    a_exp_min: assert property (p_exp_min) else $error("exposure too short");

    property p_ro_after;
        $fell(exposure_active_out) |-> readout_active_out [*8];
    endproperty
    a_ro_after: assert property (p_ro_after) else $error("no readout after exposure");

    property p_ro_start;
        $rose(readout_active_out) |-> $past(exposure_active_out);
    endproperty
    a_ro_start: assert property (p_ro_start) else $error("readout without exposure");
endmodule : etoc_props

bind etoc_exposure_timer etoc_props u_props (
    .clk_in(clk_in), .rst_in(rst_in), .bus_in(bus_in), .rdata_out(rdata_out),
    .external_trigger_in(external_trigger_in), .trigger_safe_flag_out(trigger_safe_flag_out),
    .exposure_active_out(exposure_active_out), .readout_active_out(readout_active_out));

`default_nettype wire

// File: etoc_trig_src.sv
`timescale 1ns/1ps
`default_nettype none

module etoc_trig_src (
    // clock
    input  wire logic clk_in,
    // device status
    input  wire logic trigger_safe_flag_in,
    // trigger pin
    output var logic  external_trigger_out
);
    initial external_trigger_out = 1'b0;

    // pulse long enough to pass the two-stage synchroniser
    task automatic pulse(input bit ignore_safe);
        int n;
        n = 0;
        while (!ignore_safe && trigger_safe_flag_in !== 1'b1 && n < 4000) begin
            @(negedge clk_in);
            n++;
        end
        @(posedge clk_in);
        external_trigger_out <= 1'b1;
        repeat (8) @(posedge clk_in);
        external_trigger_out <= 1'b0;
        repeat (8) @(posedge clk_in);
    endtask : pulse
endmodule : etoc_trig_src

`default_nettype wire

// File: etoc_exposure_timer_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "etoc_consts.svh"

module etoc_exposure_timer_test;
    import etoc_pkg::*;
    logic        clk_in;
    logic        rst_in;
    etoc_bus_s   bus_in;
    logic [31:0] rdata_out;
    logic [31:0] rdata_alt;
    logic        trig;
    logic        safe;
    logic        exp_act;
    logic        ro_act;
    logic [31:0] d;
    logic        ov;
    int          n_errors;
    int          tests_run;
    int          seed;
    int          m_mult;
    int          m_tick;
    int          m_ign;
    int          i;

    etoc_exposure_timer uut (.clk_in(clk_in), .rst_in(rst_in), .bus_in(bus_in),
        .rdata_out(rdata_out), .external_trigger_in(trig), .trigger_safe_flag_out(safe),
        .exposure_active_out(exp_act), .readout_active_out(ro_act));
    etoc_trig_src src (.clk_in(clk_in), .trigger_safe_flag_in(safe), .external_trigger_out(trig));
    // alternate variant shares the bus; only its read data is compared
    etoc_exposure_timer #(.ALT_VARIANT(1'b1)) uut_alt (.clk_in(clk_in), .rst_in(rst_in),
        .bus_in(bus_in), .rdata_out(rdata_alt), .external_trigger_in(trig),
        .trigger_safe_flag_out(), .exposure_active_out(), .readout_active_out());

    always #10 clk_in = ~clk_in;

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_in);
        bus_in <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge clk_in);
        bus_in.wr <= 1'b0;
    endtask : wr

    task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_in);
        bus_in <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk_in);
        bus_in.rd <= 1'b0;
        #1 d = rdata_out;
        chk(what, exp, d);
    endtask : rchk

    task automatic set_mult(input int v);
        m_mult = v < 1 ? 1 : (v > 4095 ? 4095 : v);
        wr(`ETOC_OFS_MULT, v);
        rchk("mult", `ETOC_OFS_MULT, m_mult);
        rchk("abs", `ETOC_OFS_ABS_LO, m_mult * m_tick);
    endtask : set_mult

    task automatic set_tick(input int v);
        m_tick = v < 1 ? 1 : (v > 10000000 ? 10000000 : v);
        wr(`ETOC_OFS_TICK, v);
        rchk("tick", `ETOC_OFS_TICK, m_tick);
        rchk("abs", `ETOC_OFS_ABS_LO, m_mult * m_tick);
    endtask : set_tick

    task automatic set_abs(input int v, input bit poke);
        m_mult = (v + m_tick / 2) / m_tick;
        m_mult = m_mult < 1 ? 1 : (m_mult > 4095 ? 4095 : m_mult);
        wr(`ETOC_OFS_ABS_LO, v);
        // divider still busy, so this write must vanish
        if (poke) wr(`ETOC_OFS_TICK, 7);
        repeat (42) @(posedge clk_in);
        rchk("mult from abs", `ETOC_OFS_MULT, m_mult);
        rchk("abs rounded", `ETOC_OFS_ABS_LO, m_mult * m_tick);
    endtask : set_abs

    task automatic expose(input bit mid, input int ro_us);
        int n;
        n = 0;
        fork
            src.pulse(1'b0);
        join_none
        while (exp_act !== 1'b1 && n < 5000) begin
            @(posedge clk_in);
            #1 n++;
        end
        ov = ro_act;
        n = 0;
        if (mid) begin
            repeat (20) @(posedge clk_in);
            #1 n = 20;
            fork
                src.pulse(1'b1);
            join_none
            m_ign++;
        end
        while (exp_act === 1'b1 && n < 300000) begin
            @(posedge clk_in);
            #1 n++;
        end
        chk("exposure width", m_mult * m_tick * 50, n);
        if (ro_us > 0) begin
            n = 0;
            while (ro_act === 1'b1 && n < 300000) begin
                @(posedge clk_in);
                #1 n++;
            end
            chk("readout width", ro_us * 50, n);
        end
    endtask : expose

    task automatic summarize;
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : summarize

    initial begin
        #400000;
        n_errors++;
        summarize();
    end

    initial begin
        clk_in = 1'b0;
        rst_in = 1'b1;
        bus_in = '0;
        n_errors = 0;
        tests_run = 0;
        seed = 45015;
        m_mult = 1;
        m_tick = 20;
        m_ign = 0;
        repeat (6) @(posedge clk_in);
        rst_in <= 1'b0;
        rchk("mult reset", `ETOC_OFS_MULT, 1);
        rchk("tick reset", `ETOC_OFS_TICK, 20);
        chk("alt tick reset", 1, rdata_alt);
        rchk("abs reset", `ETOC_OFS_ABS_LO, 20);
        chk("alt abs reset", 31, rdata_alt);
        rchk("readout reset", `ETOC_OFS_READOUT, 1000);
        rchk("ctrl reset", `ETOC_OFS_CTRL, 0);
        rchk("ignored reset", `ETOC_OFS_IGNORED, 0);
        rchk("unmapped", 8'h20, 0);
        set_mult(0);
        set_mult(5000);
        for (i = 0; i < 4; i++) set_mult($random(seed) & 32'h1fff);
        set_mult(1);
        set_tick(10000001);
        set_tick(62);
        chk("alt abs", m_mult * m_tick * 31, rdata_alt);
        set_abs(124, 1'b0);
        set_abs(100, 1'b0);
        set_abs(92, 1'b0);
        set_abs(186, 1'b1);
        set_tick(1);
        set_mult(3);
        wr(`ETOC_OFS_READOUT, 2);
        wr(`ETOC_OFS_CTRL, 1);
        expose(1'b0, 0);
        chk("first start overlapped", 0, ov);
        rchk("status", `ETOC_OFS_STATUS, 32'h06);
        expose(1'b1, 2);
        chk("start in readout", 1, ov);
        rchk("status", `ETOC_OFS_STATUS, 32'h14);
        rchk("ignored in exposure", `ETOC_OFS_IGNORED, m_ign);
        wr(`ETOC_OFS_READOUT, 10);
        expose(1'b0, 0);
        src.pulse(1'b1);
        m_ign++;
        #1 chk("early end refused", 0, exp_act);
        rchk("ignored in readout", `ETOC_OFS_IGNORED, m_ign);
        expose(1'b0, 0);
        chk("late start overlapped", 1, ov);
        wr(`ETOC_OFS_CTRL, 0);
        src.pulse(1'b1);
        #1 chk("disabled start", 0, exp_act);
        rchk("ignored disabled", `ETOC_OFS_IGNORED, m_ign);
        summarize();
    end
endmodule : etoc_exposure_timer_test

`default_nettype wire
